/* File: rtl/apa_edge_count.sv */
// apa_edge_count: one colour channel, flags a sample-to-sample step above threshold
// assumes samples arrive one per clock with a valid qualifier
`timescale 1ns/1ps
module apa_edge_count #(
   parameter int DW = 10
) (
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          rst_b,
   // sample stream
   input  wire logic [DW-1:0] sample,
   input  wire logic          enable,
   input  wire logic [DW-1:0] threshold,
   // result
   output logic               edge_hit
);
   logic [DW-1:0] prev_q;
   logic [DW-1:0] diff;

   assign diff     = (sample > prev_q) ? sample - prev_q : prev_q - sample;
   assign edge_hit = enable && (diff > threshold);

   always_ff @(posedge ref_clk) begin
      if (!rst_b) prev_q <= '0;
      else        prev_q <= sample;
   end
endmodule // apa_edge_count

/* File: rtl/apa_pkg.sv */
// apa_pkg: register map, field positions and encodings of the auto phase adjust block
// assumes byte-wide register port and a 6-bit sampling phase
package apa_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_ADDR    = 8'h50;
   localparam logic [7:0] STAT_ADDR   = 8'h51;
   localparam logic [7:0] VMASK_ADDR  = 8'h52;
   localparam logic [7:0] LMASK_ADDR  = 8'h53;
   localparam logic [7:0] TMASK_ADDR  = 8'h54;
   localparam logic [7:0] OPT_ADDR    = 8'h55;
   localparam logic [7:0] THR_ADDR    = 8'h56;
   localparam logic [7:0] RES3_ADDR   = 8'h57;
   localparam logic [7:0] RES2_ADDR   = 8'h58;
   localparam logic [7:0] RES1_ADDR   = 8'h59;
   localparam logic [7:0] RES0_ADDR   = 8'h5a;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] VMASK_RST   = 8'h01;
   localparam logic [7:0] LMASK_RST   = 8'h01;
   localparam logic [7:0] TMASK_RST   = 8'h01;
   localparam logic [7:0] OPT_RST     = 8'h20;
   localparam logic [7:0] THR_RST     = 8'h0a;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BLUE_OFF_BIT   = 0;
   localparam int GREEN_OFF_BIT  = 1;
   localparam int RED_OFF_BIT    = 2;
   localparam int DIR_BIT        = 3;
   localparam int SPEED_BIT      = 4;
   localparam int UPD_VS_BIT     = 5;
   localparam int SRST_BIT       = 6;
   localparam int BUSY_BIT       = 7;
   localparam int OPT_USED_MSB   = 6;
   localparam int PRE_LSB        = 0;
   localparam int POST_LSB       = 4;
   localparam int VMASK_USED     = 8'h77;
   // ----------------------------------------------------------------
   // commands and timing
   // ----------------------------------------------------------------
   localparam logic [2:0] CMD_SET_PHASE = 3'h3;
   localparam logic [2:0] CMD_APPLY_ACTIVE_WINDOW_CMD    = 3'h4;
   localparam logic [6:0] STEP_FAST     = 7'h1c;  // 28 frames
   localparam logic [6:0] STEP_SLOW     = 7'h40;  // 64 frames
   localparam int         THR_SHIFT     = 2;      // threshold times four
   // line counts for the vertical mask codes
   localparam logic [5:0] PRE_LINES  [8] = '{6'd0, 6'd1, 6'd2, 6'd4, 6'd6, 6'd8, 6'd10, 6'd12};
   localparam logic [5:0] POST_LINES [8] = '{6'd5, 6'd18, 6'd19, 6'd20, 6'd22, 6'd25, 6'd41,
                                             6'd44};
   typedef enum logic [1:0] {
      APA_IDLE  = 2'b00,
      APA_MEAS  = 2'b01,
      APA_APPLY = 2'b11
   } apa_state_type;
endpackage

/* File: rtl/apa_top.sv */
// apa_top: auto sampling-phase adjust engine with its byte register file
// assumes pixel-clock inputs synchronous to ref_clk and pulse-wide sync edges
//
// Overview of operation
// - skip 0,1,2,4,6,8,10 or 12 lines before vsync edge; default 1.
// - skip 5,18,19,20,22,25,41 or 44 lines after vsync edge; default 5.
// - skip 2*N pixels after line sync edge, N from leading mask.
// - skip 2*N pixels before line sync edge, N from trailing mask.
// - option bits 0..2 drop blue, green, red from measuring when set.
// - option bit 3 selects best (0) or worst (1) phase search.
// - each search step lasts 28 frames, or 64 with bit 4 set.
// - bit 5 clear applies phase at once, set defers to vsync.
// - soft reset bit 6 holds search logic in reset while high.
// - threshold used is register value times four, ten bits wide.
// - command write runs code 3 set phase, code 4 set window.
// - status bit 7 reads one while an adjustment runs.
`timescale 1ns/1ps
module apa_top #(
   parameter int DW    = 10,
   parameter int PW    = 6,
   parameter int LINEW = 12,
   parameter int PIXW  = 12
) (
   // clock and reset
   input  wire logic           ref_clk,
   input  wire logic           rst_b,
   // register port
   input  wire logic [7:0]     reg_addr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic      [7:0]     reg_rdata,
   // video timing
   input  wire logic           vsync_lead,
   input  wire logic           line_sync_output,
   input  wire logic [LINEW-1:0] lines_per_frame,
   input  wire logic [PIXW-1:0]  pixels_per_line,
   // samples
   input  wire logic [DW-1:0]  blue_in,
   input  wire logic [DW-1:0]  green_in,
   input  wire logic [DW-1:0]  red_in,
   // phase control
   output logic      [PW-1:0]  sample_phase,
   output logic                apply_active_window_cmd
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]             vmask_q;
   logic [7:0]             lmask_q;
   logic [7:0]             tmask_q;
   logic [7:0]             opt_q;
   logic [7:0]             thr_q;
   logic [7:0]             rdata_q;
   logic                   win_q;
   logic [PW-1:0]          phase_q;
   logic [PW-1:0]          cand_q;
   logic [PW-1:0]          best_q;
   logic [PW-1:0]          pend_q;
   logic                   pend_v_q;
   logic [31:0]            best_cnt_q;
   logic [31:0]            cnt_q;
   logic [6:0]             frame_q;
   logic [LINEW-1:0]       line_q;
   logic [PIXW-1:0]        pix_q;
   logic                   first_q;
   apa_pkg::apa_state_type st_q;
   apa_pkg::apa_state_type st_d;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire wr_cmd   = reg_wr && reg_addr == apa_pkg::CMD_ADDR;
   wire [2:0] search_command_code = reg_wdata[2:0];
   wire apply_phase_cmd = wr_cmd && search_command_code == apa_pkg::CMD_SET_PHASE;
   wire set_win  = wr_cmd && search_command_code == apa_pkg::CMD_APPLY_ACTIVE_WINDOW_CMD;
   wire search_block_reset = opt_q[apa_pkg::SRST_BIT];
   wire srst     = !rst_b || search_block_reset;
   wire search_in_progress = st_q != apa_pkg::APA_IDLE;
   wire search_direction   = opt_q[apa_pkg::DIR_BIT];
   wire search_step_length = opt_q[apa_pkg::SPEED_BIT];
   wire upd_on_vs          = opt_q[apa_pkg::UPD_VS_BIT];
   wire blue_measure_off   = opt_q[apa_pkg::BLUE_OFF_BIT];
   wire green_measure_off  = opt_q[apa_pkg::GREEN_OFF_BIT];
   wire red_measure_off    = opt_q[apa_pkg::RED_OFF_BIT];
   wire [DW-1:0] edge_quality_threshold = DW'({thr_q, 2'b00});

   // ----------------------------------------------------------------
   // measurement window
   // ----------------------------------------------------------------
   wire [5:0] pre_vsync_line_skip  = apa_pkg::PRE_LINES[vmask_q[apa_pkg::PRE_LSB +: 3]];
   wire [5:0] post_vsync_line_skip = apa_pkg::POST_LINES[vmask_q[apa_pkg::POST_LSB +: 3]];
   wire [PIXW-1:0] leading_pixel_skip  = PIXW'({lmask_q, 1'b0});
   wire [PIXW-1:0] trailing_pixel_skip = PIXW'({tmask_q, 1'b0});
   wire line_ok = (line_q >= LINEW'(post_vsync_line_skip)) &&
                  (line_q + LINEW'(pre_vsync_line_skip) < lines_per_frame);
   wire pix_ok  = (pix_q >= leading_pixel_skip) &&
                  (pix_q + trailing_pixel_skip < pixels_per_line);
   wire in_win  = line_ok && pix_ok && st_q == apa_pkg::APA_MEAS && !first_q;

   // ----------------------------------------------------------------
   // edge detectors, one per colour
   // ----------------------------------------------------------------
   logic [2:0] hit;
   apa_edge_count #(.DW(DW)) u_blue (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .sample    (blue_in),
      .enable    (in_win && !blue_measure_off),
      .threshold (edge_quality_threshold),
      .edge_hit  (hit[0])
   );
   apa_edge_count #(.DW(DW)) u_green (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .sample    (green_in),
      .enable    (in_win && !green_measure_off),
      .threshold (edge_quality_threshold),
      .edge_hit  (hit[1])
   );
   apa_edge_count #(.DW(DW)) u_red (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .sample    (red_in),
      .enable    (in_win && !red_measure_off),
      .threshold (edge_quality_threshold),
      .edge_hit  (hit[2])
   );
   wire [1:0] hits = 2'(hit[0]) + 2'(hit[1]) + 2'(hit[2]);

   // ----------------------------------------------------------------
   // search control
   // ----------------------------------------------------------------
   wire [6:0] step_len  = search_step_length ? apa_pkg::STEP_SLOW : apa_pkg::STEP_FAST;
   wire step_done = vsync_lead && (frame_q == step_len - 7'd1);
   wire better    = search_direction ? (cnt_q < best_cnt_q) : (cnt_q > best_cnt_q);
   // first candidate always seeds the record, whatever its count
   wire take      = (cand_q == '0) || better;
   wire last_cand = cand_q == {PW{1'b1}};
   wire [PW-1:0] win_phase = take ? cand_q : best_q;
   wire [PW-1:0] next_cand = cand_q + PW'(1);
   wire start_cmd = apply_phase_cmd && st_q == apa_pkg::APA_IDLE;
   wire meas_vs   = vsync_lead && st_q == apa_pkg::APA_MEAS;
   // first vsync only aligns the count, its partial frame is dropped
   wire drop_vs   = meas_vs && first_q;
   wire step_vs   = meas_vs && !first_q && step_done;
   wire count_vs  = meas_vs && !first_q && !step_done;
   wire apply_now = pend_v_q && (!upd_on_vs || vsync_lead);

   always_comb begin
      st_d = st_q;
      case (st_q)
         apa_pkg::APA_IDLE:  if (apply_phase_cmd) st_d = apa_pkg::APA_MEAS;
         apa_pkg::APA_MEAS:  if (step_vs && last_cand) st_d = apa_pkg::APA_APPLY;
         apa_pkg::APA_APPLY: if (!pend_v_q) st_d = apa_pkg::APA_IDLE;
         default:            st_d = apa_pkg::APA_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   wire wr_vmask = reg_wr && reg_addr == apa_pkg::VMASK_ADDR;
   wire wr_lmask = reg_wr && reg_addr == apa_pkg::LMASK_ADDR;
   wire wr_tmask = reg_wr && reg_addr == apa_pkg::TMASK_ADDR;
   wire wr_opt   = reg_wr && reg_addr == apa_pkg::OPT_ADDR;
   wire wr_thr   = reg_wr && reg_addr == apa_pkg::THR_ADDR;
   // reserved bits are dropped on write so they always read back as zero
   wire [7:0] vmask_d = reg_wdata & 8'(apa_pkg::VMASK_USED);
   wire [7:0] opt_d   = {1'b0, reg_wdata[apa_pkg::OPT_USED_MSB:0]};

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         vmask_q <= apa_pkg::VMASK_RST;
      end else if (wr_vmask) begin
         vmask_q <= vmask_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         lmask_q <= apa_pkg::LMASK_RST;
      end else if (wr_lmask) begin
         lmask_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tmask_q <= apa_pkg::TMASK_RST;
      end else if (wr_tmask) begin
         tmask_q <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         opt_q <= apa_pkg::OPT_RST;
      end else if (wr_opt) begin
         opt_q <= opt_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         thr_q <= apa_pkg::THR_RST;
      end else if (wr_thr) begin
         thr_q <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // read back, data the cycle after the strobe
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         apa_pkg::STAT_ADDR:  rd_mux = {search_in_progress, 7'h00};
         apa_pkg::VMASK_ADDR: rd_mux = vmask_q;
         apa_pkg::LMASK_ADDR: rd_mux = lmask_q;
         apa_pkg::TMASK_ADDR: rd_mux = tmask_q;
         apa_pkg::OPT_ADDR:   rd_mux = opt_q;
         apa_pkg::THR_ADDR:   rd_mux = thr_q;
         apa_pkg::RES3_ADDR:  rd_mux = best_cnt_q[31:24];
         apa_pkg::RES2_ADDR:  rd_mux = best_cnt_q[23:16];
         apa_pkg::RES1_ADDR:  rd_mux = best_cnt_q[15:8];
         apa_pkg::RES0_ADDR:  rd_mux = best_cnt_q[7:0];
         default:             rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         win_q <= 1'b0;
      end else begin
         win_q <= set_win;
      end
   end
   assign reg_rdata = rdata_q;
   assign apply_active_window_cmd = win_q;

   // ----------------------------------------------------------------
   // line and pixel position
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         line_q <= '0;
         pix_q  <= '0;
      end else begin
         if (vsync_lead)            line_q <= '0;
         else if (line_sync_output) line_q <= line_q + LINEW'(1);
         if (line_sync_output)      pix_q  <= '0;
         else                       pix_q  <= pix_q + PIXW'(1);
      end
   end

   // ----------------------------------------------------------------
   // search state
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= apa_pkg::APA_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || start_cmd) begin
         cand_q <= '0;
      end else if (step_vs) begin
         cand_q <= next_cand;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         best_q     <= '0;
         best_cnt_q <= '0;
      end else if (step_vs && take) begin
         best_q     <= cand_q;
         best_cnt_q <= cnt_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || start_cmd || drop_vs || step_vs) begin
         cnt_q <= '0;
      end else if (in_win && !meas_vs) begin
         cnt_q <= cnt_q + 32'(hits);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || start_cmd || drop_vs || step_vs) begin
         frame_q <= '0;
      end else if (count_vs) begin
         frame_q <= frame_q + 7'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst || start_cmd) begin
         first_q <= 1'b1;
      end else if (drop_vs) begin
         first_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // phase update, immediate or on next vsync
   // ----------------------------------------------------------------
   // a new candidate wins over the clearing of the one just applied
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pend_q   <= '0;
         pend_v_q <= 1'b0;
      end else if (step_vs) begin
         pend_q   <= last_cand ? win_phase : next_cand;
         pend_v_q <= 1'b1;
      end else if (apply_now) begin
         pend_v_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_q <= '0;
      end else if (apply_now) begin
         phase_q <= pend_q;
      end
   end
   assign sample_phase = phase_q;
endmodule // apa_top

/* File: verif/apa_top_asserts.sv */
// apa_top_asserts: port-level checks of the phase adjust block
// assumes it is bound onto apa_top with at most one strobe per cycle
`timescale 1ns/1ps
module apa_top_asserts #(
   parameter int PW = 6
) (
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          rst_b,
   // register port
   input wire logic [7:0]    reg_addr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_wr,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   // phase control
   input wire logic [PW-1:0] sample_phase,
   input wire logic          apply_active_window_cmd
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // mirror of the soft reset bit, so the hold can be judged from the ports
   logic srst_q;
   wire  cmd_de = reg_wr && reg_addr == 8'h50 && reg_wdata[2:0] == 3'h4;
   wire  rd_st  = reg_rd && reg_addr == 8'h51;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         srst_q <= 1'b0;
      end else if (reg_wr && reg_addr == 8'h55) begin
         srst_q <= reg_wdata[6];
      end
   end
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
   property p_de_cmd; cmd_de |=> apply_active_window_cmd; endproperty
   a_de_cmd: assert property (p_de_cmd) else $error("window pulse missing");
   property p_de_only; !cmd_de |=> !apply_active_window_cmd; endproperty
   a_de_only: assert property (p_de_only) else $error("window pulse unasked");
   property p_stat; rd_st |=> reg_rdata[6:0] == 7'h00; endproperty
   a_stat: assert property (p_stat) else $error("status low bits set");
   property p_vmask; reg_rd && reg_addr == 8'h52 |=> !reg_rdata[3] && !reg_rdata[7]; endproperty
   a_vmask: assert property (p_vmask) else $error("line mask spare bits set");
   property p_thr;
      reg_wr && reg_addr == 8'h56 ##2 reg_rd && reg_addr == 8'h56 |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_thr: assert property (p_thr) else $error("threshold readback differs");
   property p_srst_ph; srst_q && $past(srst_q) |-> sample_phase == '0; endproperty
   a_srst_ph: assert property (p_srst_ph) else $error("phase moved in soft reset");
   property p_srst_busy; srst_q && $past(srst_q) && rd_st |=> !reg_rdata[7]; endproperty
   a_srst_busy: assert property (p_srst_busy) else $error("busy in soft reset");
   property p_unmap; reg_rd && (reg_addr < 8'h50 || reg_addr > 8'h5a) |=> reg_rdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // apa_top_asserts
bind apa_top apa_top_asserts #(.PW(PW)) u_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sample_phase(sample_phase),
   .apply_active_window_cmd(apply_active_window_cmd));

/* File: verif/apa_top_test.sv */
// apa_top_test: self-checking bench of the phase adjust block
// assumes one 20 MHz clock and a bench-made raster of 4 lines by 8 pixels
`timescale 1ns/1ps
module apa_top_test;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_rdata;
   logic        vsync_lead = 1'b0;
   logic        line_sync_output = 1'b0;
   logic [9:0]  blue_in = 10'h000;
   logic [9:0]  green_in = 10'h000;
   logic [9:0]  red_in = 10'h000;
   logic [5:0]  sample_phase;
   logic        apply_active_window_cmd;
   logic [31:0] seed = 32'h22a1f12e;
   logic [31:0] v;
   logic [31:0] u;
   logic [4:0]  pix = 5'h00;
   logic [7:0]  d;
   logic [7:0]  x;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   localparam logic [7:0] RSTV [5] = '{apa_pkg::VMASK_RST, apa_pkg::LMASK_RST,
      apa_pkg::TMASK_RST, apa_pkg::OPT_RST, apa_pkg::THR_RST};
   localparam logic [7:0] BADA [3] = '{8'h4f, 8'h5b, 8'hff};
   always #25 ref_clk = ~ref_clk;
   apa_top u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vsync_lead(vsync_lead),
      .line_sync_output(line_sync_output), .lines_per_frame(12'h004),
      .pixels_per_line(12'h008), .blue_in(blue_in), .green_in(green_in), .red_in(red_in),
      .sample_phase(sample_phase), .apply_active_window_cmd(apply_active_window_cmd));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // unused bits of the line mask and the option byte read back as zero
   function automatic logic [7:0] expv(input int i, input logic [7:0] w);
      return (i == 0) ? (w & 8'h77) : (i == 3) ? (w & 8'h7f) : w;
   endfunction
   // ----------------------------------------------------------------
   // raster, samples and watchdog
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      v = rnd();
      pix              <= pix + 5'h01;
      line_sync_output <= pix[2:0] == 3'h7;
      vsync_lead       <= pix == 5'h1f;
      blue_in          <= v[9:0];
      green_in         <= v[19:10];
      red_in           <= v[29:20];
      cycles           <= cycles + 1;
      if (cycles > 5000) begin
         mismatches = mismatches + 1;
         report_and_stop();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= w;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      r = reg_rdata;
   endtask
   task automatic wait_vs(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         while (vsync_lead !== 1'b1) @(posedge ref_clk);
      end
   endtask
   task automatic report_and_stop();
      $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(apa_pkg::VMASK_ADDR + i[7:0], d);
         chk("reset value", RSTV[i], d);
      end
      $display("test reset values done");
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 5; i++) begin
            u = rnd();
            x = (k == 0) ? 8'hff : u[7:0];
            // soft reset stays off here, pixel masks stay nonzero
            x = (i == 3) ? (x & 8'hbf) : (i == 1 || i == 2) ? (x | 8'h01) : x;
            wr(apa_pkg::VMASK_ADDR + i[7:0], x);
            rd(apa_pkg::VMASK_ADDR + i[7:0], d);
            chk("readback", expv(i, x), d);
         end
      end
      for (int i = 0; i < 5; i++) wr(apa_pkg::VMASK_ADDR + i[7:0], RSTV[i]);
      for (int i = 0; i < 3; i++) begin
         wr(BADA[i], 8'h5a);
         rd(BADA[i], d);
         chk("unmapped", 8'h00, d);
      end
      $display("test register access done");
      for (int c = 0; c < 8; c++) begin
         if (c != 3) begin
            wr(apa_pkg::CMD_ADDR, {5'h1f, c[2:0]});
            @(negedge ref_clk);
            chk("window pulse", {7'h00, c == 4}, {7'h00, apply_active_window_cmd});
            rd(apa_pkg::STAT_ADDR, d);
            chk("status idle", 8'h00, d);
         end
      end
      wr(apa_pkg::CMD_ADDR, {5'h00, apa_pkg::CMD_SET_PHASE});
      rd(apa_pkg::STAT_ADDR, d);
      chk("status busy", 8'h80, d);
      wr(apa_pkg::CMD_ADDR, {5'h00, apa_pkg::CMD_APPLY_ACTIVE_WINDOW_CMD});
      @(negedge ref_clk);
      chk("window pulse busy", 8'h01, {7'h00, apply_active_window_cmd});
      $display("test commands done");
      wait_vs(27);
      @(negedge ref_clk);
      chk("phase held", 8'h00, {2'b00, sample_phase});
      wait_vs(4);
      @(negedge ref_clk);
      chk("phase stepped", 8'h01, {2'b00, sample_phase});
      $display("test search step done");
      wr(apa_pkg::OPT_ADDR, apa_pkg::OPT_RST | 8'h40);
      rd(apa_pkg::STAT_ADDR, d);
      chk("soft reset busy", 8'h00, d);
      chk("soft reset phase", 8'h00, {2'b00, sample_phase});
      wr(apa_pkg::CMD_ADDR, {5'h00, apa_pkg::CMD_SET_PHASE});
      rd(apa_pkg::STAT_ADDR, d);
      chk("start in soft reset", 8'h00, d);
      wr(apa_pkg::OPT_ADDR, apa_pkg::OPT_RST);
      rd(apa_pkg::STAT_ADDR, d);
      chk("after soft reset", 8'h00, d);
      $display("test soft reset done");
      wr(apa_pkg::OPT_ADDR, 8'h00);
      wait_vs(1);
      wr(apa_pkg::CMD_ADDR, {5'h00, apa_pkg::CMD_SET_PHASE});
      wait_vs(29);
      @(negedge ref_clk);
      chk("phase before step end", 8'h00, {2'b00, sample_phase});
      @(negedge ref_clk);
      chk("phase applied at once", 8'h01, {2'b00, sample_phase});
      for (int i = 0; i < 4; i++) begin
         rd(apa_pkg::RES3_ADDR + i[7:0], d);
         chk("result byte", 8'h00, d);
      end
      $display("test immediate update done");
      report_and_stop();
   end
endmodule // apa_top_test
